// *** dv/asr_host_model.sv ***
// Behavioural host serial port that reads one result word per frame.
`timescale 1ns/1ns
`default_nettype none
module asr_host_model (
	output logic o_cs_n,
	output logic o_fs,
	output logic o_sclk,
	input wire logic i_sdo_w,
	input wire logic i_oe
);
	// Idle pins: chip select high, frame sync high when unused, clock parked low.
	initial begin
		o_cs_n = 1'b1;
		o_fs = 1'b1;
		o_sclk = 1'b0;
	end

	// One frame; the clock runs only inside it, 32 ns high and 40 ns low to stay under the limit.
	task automatic run_frame(input logic fs_mode, input int n_rises, output logic [15:0] word,
		output logic ok_wait, output logic ok_float);
		word = 16'h0000;
		ok_wait = 1'b1;
		o_fs = !fs_mode;
		#40;
		o_cs_n = 1'b0;
		if (fs_mode) begin
			#40;
			ok_wait = (i_oe === 1'b1) && (i_sdo_w === 1'b0);
			o_fs = 1'b1;
		end
		#40;
		shift_word(n_rises, word);
		if (n_rises >= 17) begin
			#20;
			ok_float = (i_oe === 1'b0);
			o_cs_n = 1'b1;
		end else begin
			o_cs_n = 1'b1;
			#20;
			ok_float = (i_oe === 1'b0);
		end
		#40;
	endtask : run_frame

	// Clocks the word in: MSB before the first rise, each later bit after its falling edge.
	task automatic shift_word(input int n_rises, inout logic [15:0] word);
		word[15] = i_sdo_w;
		for (int i = 1; i <= n_rises; i++) begin
			o_sclk = 1'b1;
			#32;
			o_sclk = 1'b0;
			#40;
			if (i < 16) word[15-i] = i_sdo_w;
		end
	endtask : shift_word

	// Two frame-sync frames with chip select left low between them, as a grounded pin would be.
	// The second frame opens from idle on the frame-sync rise alone.
	task automatic run_fs_held(output logic [15:0] w1, output logic [15:0] w2,
		output logic ok_float);
		w1 = 16'h0000;
		w2 = 16'h0000;
		o_fs = 1'b0;
		#40;
		o_cs_n = 1'b0;
		#40;
		o_fs = 1'b1;
		#40;
		shift_word(17, w1);
		#20;
		o_fs = 1'b0;
		#40;
		o_fs = 1'b1;
		#40;
		shift_word(17, w2);
		#20;
		ok_float = (i_oe === 1'b0);
		o_cs_n = 1'b1;
		#40;
	endtask : run_fs_held
endmodule : asr_host_model
`default_nettype wire

// *** dv/asr_port_props.sv ***
// Concurrent checks on the serial result readout port pins.
`timescale 1ns/1ns
`default_nettype none
module asr_port_props (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_frame_sync_in,
	input wire logic i_start,
	input wire logic o_result_serial_out,
	input wire logic o_result_serial_oe,
	input wire logic o_power_down
);
	// --------------------------------------------------------------
	// Helper counters
	// --------------------------------------------------------------
	logic [4:0] rises;
	logic [3:0] since;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// Serial clock rises seen in the open frame; a frame-sync rise restarts the count.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) rises <= 5'h00;
		else if (i_cs_n || $rose(i_frame_sync_in)) rises <= 5'h00;
		else if ($rose(i_sclk) && rises != 5'h1F) rises <= rises + 5'h01;
	end

	// Cycles since the last launching edge, saturating so it never wraps to a false cause.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) since <= 4'hF;
		else if ($rose(i_sclk) || $rose(i_frame_sync_in)) since <= 4'h0;
		else if (since != 4'hF) since <= since + 4'h1;
	end

	a_cs_fall_enable: assert property ($fell(i_cs_n) |-> ##[1:5] o_result_serial_oe)
		else $error("output not enabled after chip select fall");
	a_cs_high_float: assert property (i_cs_n [*5] |-> !o_result_serial_oe)
		else $error("output driven while chip select high");
	a_idle_low: assert property (!o_result_serial_oe |-> !o_result_serial_out)
		else $error("data high while output floats");
	a_bit_change_cause: assert property (o_result_serial_oe && $past(o_result_serial_oe)
		&& $changed(o_result_serial_out) |-> since <= 4'h6)
		else $error("data changed without a launching edge");
	a_float_after_end: assert property ($changed(rises) && rises == 5'd17
		|-> ##[0:6] !o_result_serial_oe)
		else $error("output still driven after the frame end edge");
	a_cs_rise_float: assert property ($rose(i_cs_n) |-> ##[1:5] !o_result_serial_oe)
		else $error("output still driven after chip select rise");
	a_start_wakes: assert property (i_start |-> ##[1:3] !o_power_down)
		else $error("conversion request left block powered down");
	a_frame_wakes: assert property ($rose(o_result_serial_oe) |-> ##[0:2] !o_power_down)
		else $error("powered down during a frame");
endmodule : asr_port_props
bind asr_port asr_port_props asr_port_props_i (
	.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n),
	.i_sclk(i_sclk),
	.i_cs_n(i_cs_n),
	.i_frame_sync_in(i_frame_sync_in),
	.i_start(i_start),
	.o_result_serial_out(o_result_serial_out),
	.o_result_serial_oe(o_result_serial_oe),
	.o_power_down(o_power_down)
);
`default_nettype wire

// *** dv/asr_port_tb.sv ***
// Self-checking bench for the serial result readout port.
`timescale 1ns/1ns
`default_nettype none
module asr_port_tb;
	import asr_pkg::*;
	// --------------------------------------------------------------
	// Clock, pins and instances
	// --------------------------------------------------------------
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_start = 1'b0;
	logic i_ce = 1'b1;
	logic [DATA_W-1:0] i_analog_in = 16'hA5C3;
	logic cs_n, fs, sclk, result_serial_out, oe, pd, underrun, ok_wait, ok_float;
	logic [DATA_W-1:0] word;
	wire logic sdo_w;
	int miscompares = 0;
	int cmp_count = 0;

	always #2 i_clk_sys = ~i_clk_sys;
	// The host sees a floating line, never a stale bit, while the output is disabled.
	assign sdo_w = oe ? result_serial_out : 1'bz;

	asr_port asr_port_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_frame_sync_in(fs), .i_start(i_start), .i_analog_in(i_analog_in),
		.o_result_serial_out(result_serial_out), .o_result_serial_oe(oe), .o_power_down(pd),
		.o_underrun(underrun));
	asr_host_model asr_host_model_i (.o_cs_n(cs_n), .o_fs(fs), .o_sclk(sclk), .i_sdo_w(sdo_w),
		.i_oe(oe));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic frame(input logic fs_mode, input int n, input logic [DATA_W-1:0] exp);
		asr_host_model_i.run_frame(fs_mode, n, word, ok_wait, ok_float);
		check("word", word, exp);
		check("float at frame end", ok_float, 1'b1);
	endtask : frame

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset_idle();
		repeat (6) @(negedge i_clk_sys);
		check("oe in reset", oe, 1'b0);
		i_rst_n = 1'b1;
		repeat (20) @(negedge i_clk_sys);
		check("awake while converting", pd, 1'b0);
		repeat (730) @(negedge i_clk_sys);
		check("idle after conversion", pd, 1'b1);
		check("oe with cs high", oe, 1'b0);
	endtask : t_reset_idle

	// Chip-select framing, ended early by chip select as an SPI master does.
	task automatic t_spi_frame();
		@(negedge i_clk_sys);
		i_analog_in = 16'hFFFF;
		frame(1'b0, 16, 16'hA5C3);
		check("no underrun", underrun, 1'b0);
	endtask : t_spi_frame

	// Frame-sync framing back to back, so the buffer is empty and the last word repeats.
	task automatic t_dsp_underrun();
		frame(1'b1, 17, 16'hA5C3);
		check("fs wait state", ok_wait, 1'b1);
		check("underrun flagged", underrun, 1'b1);
		repeat (2000) @(negedge i_clk_sys);
		frame(1'b1, 17, 16'hFFFF);
		check("underrun cleared", underrun, 1'b0);
		repeat (800) @(negedge i_clk_sys);
	endtask : t_dsp_underrun

	// Two words wait already; 30 more fill the buffer and one further result is held back.
	task automatic t_fifo_fill_drain();
		for (int k = 0; k <= 30; k++) begin
			@(negedge i_clk_sys);
			i_analog_in = 16'h0101 * k[DATA_W-1:0];
			i_start = 1'b1;
			@(negedge i_clk_sys);
			i_start = 1'b0;
			repeat (750) @(negedge i_clk_sys);
		end
		i_analog_in = 16'hFFFF;
		for (int k = 0; k <= FIFO_DEPTH; k++) begin
			frame(1'b0, 16, (k < 2) ? 16'hFFFF : 16'h0101 * (k[DATA_W-1:0] - 16'h0002));
			check("no underrun in drain", underrun, 1'b0);
		end
	endtask : t_fifo_fill_drain

	// Chip select held low across two frame-sync frames; the buffer holds only full-scale words.
	task automatic t_fs_held();
		logic [DATA_W-1:0] w2;
		asr_host_model_i.run_fs_held(word, w2, ok_float);
		check("held cs first word", word, 16'hFFFF);
		check("held cs second word", w2, 16'hFFFF);
		check("float after held frame", ok_float, 1'b1);
		check("no underrun held cs", underrun, 1'b0);
	endtask : t_fs_held

	// Enable low freezes a running conversion; it only finishes once enable returns.
	task automatic t_ce_freeze();
		repeat (1600) @(negedge i_clk_sys);
		check("idle before freeze", pd, 1'b1);
		i_start = 1'b1;
		@(negedge i_clk_sys);
		i_start = 1'b0;
		repeat (10) @(negedge i_clk_sys);
		i_ce = 1'b0;
		repeat (800) @(negedge i_clk_sys);
		check("conversion frozen", pd, 1'b0);
		i_ce = 1'b1;
		repeat (740) @(negedge i_clk_sys);
		check("idle after thaw", pd, 1'b1);
	endtask : t_ce_freeze

	// --------------------------------------------------------------
	// Sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		t_reset_idle();
		t_spi_frame();
		t_dsp_underrun();
		t_fifo_fill_drain();
		t_fs_held();
		t_ce_freeze();
		report_and_stop();
	end

	// The sequence needs about 170 us; allow over twice that before calling it a hang.
	initial begin
		#400000;
		miscompares++;
		report_and_stop();
	end
endmodule : asr_port_tb
`default_nettype wire

// *** verilog/asr_conv.sv ***
// Conversion timer: samples the input and delivers a result after a fixed time.
`timescale 1ns/1ns
`default_nettype none
module asr_conv (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic [asr_pkg::DATA_W-1:0] i_analog_in,
	output logic o_valid,
	input wire logic i_ready,
	output logic [asr_pkg::DATA_W-1:0] o_data,
	output logic o_busy
);
	import asr_pkg::*;

	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

	logic pending;
	logic [CONV_CNT_W-1:0] cnt;
	logic launch;

	// A new conversion needs a request and an empty output slot.
	assign launch = pending && !o_busy && !o_valid;

	// --------------------------------------------------------------
	// Request latch
	// --------------------------------------------------------------
	// Reset leaves one request pending so the first result is ready
	// before the first frame; a request in the launch cycle wins.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pending <= 1'b1;
		end else if (i_ce) begin
			if (i_start) begin
				pending <= 1'b1;
			end else if (launch) begin
				pending <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Conversion timer
	// --------------------------------------------------------------
	// The system clock stands in for the internal oscillator.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy <= 1'b0;
			cnt <= '0;
		end else if (i_ce) begin
			if (launch) begin
				o_busy <= 1'b1;
				cnt <= CONV_LAST;
			end else if (o_busy && cnt == '0) begin
				o_busy <= 1'b0;
			end else if (o_busy) begin
				cnt <= cnt - 1'b1;
			end
		end
	end

	// Sample taken at launch, coded as straight binary.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data <= RESULT_RESET;
		end else if (i_ce && launch) begin
			o_data <= i_analog_in;
		end
	end

	// Result held until the buffer takes it, stalling the next launch.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
		end else if (i_ce) begin
			if (o_busy && cnt == '0) begin
				o_valid <= 1'b1;
			end else if (i_ready) begin
				o_valid <= 1'b0;
			end
		end
	end

endmodule : asr_conv
`default_nettype wire

// *** verilog/asr_fifo.sv ***
// Result buffer between the converter and the serial port.
`timescale 1ns/1ns
`default_nettype none
module asr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	// --------------------------------------------------------------
	// Flags
	// --------------------------------------------------------------
	// The extra pointer bit tells full from empty without a counter.
	assign o_out_valid = (wr_ptr != rd_ptr);
	assign o_in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
	assign push = i_ce && i_in_valid && o_in_ready;
	assign pop = i_ce && o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr[AW-1:0]];

	// --------------------------------------------------------------
	// Storage and pointers
	// --------------------------------------------------------------
	// Storage is written only; it needs no reset.
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end

	// Write pointer advances on every accepted word.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Read pointer advances on every delivered word.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule : asr_fifo
`default_nettype wire

// *** verilog/asr_pkg.sv ***
// Shared constants, types and helpers for the serial result readout port.
package asr_pkg;

	// --------------------------------------------------------------
	// Word and buffer geometry
	// --------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_AW = 5;
	localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;

	// --------------------------------------------------------------
	// Serial frame figures
	// --------------------------------------------------------------
	localparam int BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] FRAME_END_EDGE = 5'h11;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT_EDGE = 5'h0F;
	localparam logic [3:0] MSB_INDEX = 4'hF;
	// Fastest serial clock the host may apply, kept for the bench.
	localparam int SCLK_MAX_KHZ = 15000;

	// --------------------------------------------------------------
	// Conversion timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_NS = 2940;
	// A longest time rounds down to whole cycles.
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = 10;

	// --------------------------------------------------------------
	// Frame sequencer states
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_FS = 2'b01,
		ST_SHIFT = 2'b10
	} asr_state_t;

	// Binary to gray code for the edge counter crossing.
	function automatic logic [BIT_CNT_W-1:0] asr_bin2gray(input logic [BIT_CNT_W-1:0] b);
		asr_bin2gray = b ^ (b >> 1);
	endfunction : asr_bin2gray

	// Gray code back to binary on the receiving side.
	function automatic logic [BIT_CNT_W-1:0] asr_gray2bin(input logic [BIT_CNT_W-1:0] g);
		logic [BIT_CNT_W-1:0] b;
		b = g;
		for (int i = BIT_CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		asr_gray2bin = b;
	endfunction : asr_gray2bin

endpackage : asr_pkg

// *** verilog/asr_port.sv ***
// Serial result readout port: frame sequencer, link edge counter and buffering.
`timescale 1ns/1ns
`default_nettype none
module asr_port (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_frame_sync_in,
	input wire logic i_start,
	input wire logic [asr_pkg::DATA_W-1:0] i_analog_in,
	output logic o_result_serial_out,
	output logic o_result_serial_oe,
	output logic o_power_down,
	output logic o_underrun
);
	import asr_pkg::*;

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	asr_state_t state;
	asr_state_t next_state;
	logic cs_s1;
	logic cs_s2;
	logic cs_q;
	logic fs_s1;
	logic fs_s2;
	logic fs_q;
	logic cs_fall;
	logic cs_rise;
	logic fs_rise;
	logic fs_mode;
	logic frame_start;
	logic frame_end;
	logic link_clr;
	logic [BIT_CNT_W-1:0] edge_cnt;
	logic [BIT_CNT_W-1:0] edge_gray;
	logic [BIT_CNT_W-1:0] gray_s1;
	logic [BIT_CNT_W-1:0] gray_s2;
	logic [BIT_CNT_W-1:0] edges_seen;
	logic [DATA_W-1:0] word;
	logic [3:0] bit_idx;
	logic next_oe;
	logic conv_valid;
	logic conv_ready;
	logic conv_busy;
	logic [DATA_W-1:0] conv_data;
	logic buf_valid;
	logic [DATA_W-1:0] buf_data;

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	// Chip select and frame sync are pins; two flops before any use.
	// Chip select resets high so a grounded pin reads as a fall.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_q <= 1'b1;
		end else if (i_ce) begin
			cs_s1 <= i_cs_n;
			cs_s2 <= cs_s1;
			cs_q <= cs_s2;
		end
	end

	// Frame sync rests high when unused, so it resets high too.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fs_s1 <= 1'b1;
			fs_s2 <= 1'b1;
			fs_q <= 1'b1;
		end else if (i_ce) begin
			fs_s1 <= i_frame_sync_in;
			fs_s2 <= fs_s1;
			fs_q <= fs_s2;
		end
	end

	// Edges are taken from the second stage and its delayed copy.
	assign cs_fall = cs_q && !cs_s2;
	assign cs_rise = !cs_q && cs_s2;
	assign fs_rise = !fs_q && fs_s2;

	// --------------------------------------------------------------
	// Link-side edge counter
	// --------------------------------------------------------------
	// Runs on the host serial clock, which stops between frames, so the
	// count is cleared by the frame's own idle level, not by an edge.
	always_ff @(posedge i_sclk or posedge link_clr) begin
		if (link_clr) begin
			edge_cnt <= '0;
			edge_gray <= '0;
		end else if (edge_cnt != FRAME_END_EDGE) begin
			edge_cnt <= edge_cnt + 1'b1;
			edge_gray <= asr_bin2gray(edge_cnt + 1'b1);
		end
	end

	// Gray count crosses to the system clock one bit change at a time.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gray_s1 <= '0;
			gray_s2 <= '0;
		end else if (i_ce) begin
			gray_s1 <= edge_gray;
			gray_s2 <= gray_s1;
		end
	end

	assign edges_seen = asr_gray2bin(gray_s2);

	// --------------------------------------------------------------
	// Frame sequencer
	// --------------------------------------------------------------
	// A frame opens on a chip-select fall, or on a frame-sync rise while
	// chip select is held low in frame-sync mode.
	always_comb begin
		next_state = state;
		frame_start = 1'b0;
		frame_end = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (cs_fall && fs_s2) begin
					next_state = ST_SHIFT;
					frame_start = 1'b1;
				end else if (cs_fall) begin
					next_state = ST_WAIT_FS;
				end else if (!cs_s2 && fs_mode && fs_rise) begin
					next_state = ST_SHIFT;
					frame_start = 1'b1;
				end
			end
			ST_WAIT_FS: begin
				if (cs_rise) begin
					next_state = ST_IDLE;
				end else if (fs_rise) begin
					next_state = ST_SHIFT;
					frame_start = 1'b1;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					next_state = ST_IDLE;
					frame_end = 1'b1;
				end else if (edges_seen == FRAME_END_EDGE) begin
					next_state = ST_IDLE;
					frame_end = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
		end else if (i_ce) begin
			state <= next_state;
		end
	end

	// Framing mode is fixed by frame sync at the chip-select fall.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fs_mode <= 1'b0;
		end else if (i_ce && cs_fall) begin
			fs_mode <= !fs_s2;
		end
	end

	// Counter is held clear outside the shifting state.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_clr <= 1'b1;
		end else if (i_ce) begin
			link_clr <= (next_state != ST_SHIFT);
		end
	end

	// --------------------------------------------------------------
	// Word capture
	// --------------------------------------------------------------
	// The buffered result is taken at frame start; an empty buffer
	// resends the previous word and flags the underrun.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			word <= RESULT_RESET;
		end else if (i_ce && frame_start && buf_valid) begin
			word <= buf_data;
		end
	end

	// Underrun level reports how the last frame was served.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_underrun <= 1'b0;
		end else if (i_ce && frame_start) begin
			o_underrun <= !buf_valid;
		end
	end

	// --------------------------------------------------------------
	// Serial output
	// --------------------------------------------------------------
	// Bit index follows the edge count and holds the LSB after the
	// sixteenth bit until the frame closes.
	assign bit_idx = (edges_seen > LAST_BIT_EDGE) ? 4'h0 : (MSB_INDEX - edges_seen[3:0]);

	// Enable follows the next state so the pin turns with the frame.
	assign next_oe = (next_state != ST_IDLE) && !cs_s2;

	// Data pin: low while waiting, MSB at frame start, then the bit chosen by the count.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_result_serial_out <= 1'b0;
		end else if (i_ce) begin
			if (next_state == ST_SHIFT && frame_start && buf_valid) begin
				o_result_serial_out <= buf_data[MSB_INDEX];
			end else if (next_state == ST_SHIFT && frame_start) begin
				o_result_serial_out <= word[MSB_INDEX];
			end else if (next_state == ST_SHIFT) begin
				o_result_serial_out <= word[bit_idx];
			end else begin
				o_result_serial_out <= 1'b0;
			end
		end
	end

	// Output enable: on from the chip-select fall, or a frame opening with select held low, until the frame closes.
	// The delay is the two-flop synchroniser plus this flop.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_result_serial_oe <= 1'b0;
		end else if (i_ce) begin
			o_result_serial_oe <= next_oe;
		end
	end

	// --------------------------------------------------------------
	// Conversion and buffering
	// --------------------------------------------------------------
	// Each finished frame requests the next conversion.
	asr_conv u_conv (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_start(frame_end || i_start),
		.i_analog_in(i_analog_in),
		.o_valid(conv_valid),
		.i_ready(conv_ready),
		.o_data(conv_data),
		.o_busy(conv_busy)
	);

	// A full buffer stalls the converter through its ready.
	asr_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_in_valid(conv_valid),
		.o_in_ready(conv_ready),
		.i_in_data(conv_data),
		.o_out_valid(buf_valid),
		.i_out_ready(frame_start),
		.o_out_data(buf_data)
	);

	// --------------------------------------------------------------
	// Power state
	// --------------------------------------------------------------
	// Outside reset, power-down shows whenever nothing is converting or framed.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_power_down <= 1'b0;
		end else if (i_ce) begin
			o_power_down <= !conv_busy && (next_state == ST_IDLE);
		end
	end

endmodule : asr_port
`default_nettype wire
